// ### rtl/tldw_channel.sv
// Design decisions made here: the trapezoid phase sequence and the exponential duty table.
`timescale 1ns/1ps
module tldw_channel (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Settings
    input wire logic level_en_i,
    input wire logic wave_en_i,
    input wire logic [4:0] high_i,
    input wire logic [4:0] low_i,
    input wire logic [7:0] delay_i,
    input wire logic [7:0] rise_i,
    input wire logic [7:0] fall_i,
    input wire logic [7:0] thigh_i,
    input wire logic [7:0] tlow_i,
    // Timebase
    tldw_tick_if.snk tb,
    // Output
    output logic pwm_o,
    output logic [4:0] level_o,
    output logic [2:0] phase_o
);
    tldw_pkg::tldw_phase_t ph_q;
    logic [4:0] lvl_q;
    logic [8:0] cnt_q;
    logic [8:0] duty;
    logic [4:0] code;
    logic [8:0] lim_rise;
    logic [8:0] lim_fall;
    logic cnt_done;

    // 0.9^(31-n) scaled to 256 slots; code 31 needs the ninth bit to stay on all period
    function automatic logic [8:0] exp_duty(input logic [4:0] n);
        logic [8:0] t [32];
        t = '{9'h000, 9'h00B, 9'h00C, 9'h00D, 9'h00F, 9'h011, 9'h012, 9'h014,
              9'h017, 9'h019, 9'h01C, 9'h01F, 9'h023, 9'h026, 9'h02B, 9'h02F,
              9'h035, 9'h03B, 9'h041, 9'h048, 9'h050, 9'h059, 9'h063, 9'h06E,
              9'h07A, 9'h088, 9'h097, 9'h0A8, 9'h0BB, 9'h0CF, 9'h0E6, 9'h100};
        return t[n];
    endfunction

    // Zero rise or fall code means one PWM base tick per level
    assign lim_rise = (rise_i == 8'h00) ? 9'h001 : {1'b0, rise_i};
    assign lim_fall = (fall_i == 8'h00) ? 9'h001 : {1'b0, fall_i};
    assign code = wave_en_i ? lvl_q : (level_en_i ? high_i : 5'h00);
    assign duty = exp_duty(code);
    assign cnt_done = tb.base_tick && (cnt_q <= 9'h001);
    assign phase_o = (ph_q == tldw_pkg::TLDW_RISE) ? 3'h1 :
                     (ph_q == tldw_pkg::TLDW_HIGH) ? 3'h2 :
                     (ph_q == tldw_pkg::TLDW_FALL) ? 3'h3 :
                     (ph_q == tldw_pkg::TLDW_DELAY) ? 3'h4 : 3'h0;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pwm_o <= 1'b0;
            level_o <= 5'h00;
        end else begin
            pwm_o <= (code != 5'h00) && ({1'b0, tb.pwm_cnt} < duty);
            level_o <= code;
        end
    end

    // A disabled channel holds TLDW_DELAY; TLDW_IDLE is reached only with wave on, as the low hold
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !wave_en_i) begin
            ph_q <= tldw_pkg::TLDW_DELAY;
            lvl_q <= low_i;
            cnt_q <= {1'b0, delay_i};
        end else begin
            unique case (ph_q)
                tldw_pkg::TLDW_DELAY: begin
                    if (cnt_q == 9'h000) begin
                        ph_q <= tldw_pkg::TLDW_RISE;
                        cnt_q <= lim_rise;
                    end else if (tb.step_tick) begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                tldw_pkg::TLDW_RISE: begin
                    if (lvl_q >= high_i) begin
                        ph_q <= tldw_pkg::TLDW_HIGH;
                        cnt_q <= {1'b0, thigh_i} + 9'h001;
                    end else if (cnt_done) begin
                        lvl_q <= lvl_q + 5'h01;
                        cnt_q <= lim_rise;
                    end else if (tb.base_tick) begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                tldw_pkg::TLDW_HIGH: begin
                    if (cnt_done) begin
                        ph_q <= tldw_pkg::TLDW_FALL;
                        cnt_q <= lim_fall;
                    end else if (tb.base_tick) begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                tldw_pkg::TLDW_FALL: begin
                    if (lvl_q <= low_i) begin
                        ph_q <= tldw_pkg::TLDW_IDLE;
                        cnt_q <= {1'b0, tlow_i} + 9'h001;
                    end else if (cnt_done) begin
                        lvl_q <= lvl_q - 5'h01;
                        cnt_q <= lim_fall;
                    end else if (tb.base_tick) begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                tldw_pkg::TLDW_IDLE: begin
                    if (cnt_done) begin
                        ph_q <= tldw_pkg::TLDW_RISE;
                        cnt_q <= lim_rise;
                    end else if (tb.base_tick) begin
                        cnt_q <= cnt_q - 9'h001;
                    end
                end
                default: begin
                    ph_q <= tldw_pkg::TLDW_DELAY;
                end
            endcase
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    AST_ZERO_OFF: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        (code == 5'h00) |=> !pwm_o)
        else $error("zero code drove current");
    AST_LVL_BOUND: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wave_en_i && $past(wave_en_i) && low_i <= high_i && $stable(low_i)
         && $stable(high_i) && ph_q != tldw_pkg::TLDW_DELAY)
        |-> (lvl_q <= high_i && lvl_q >= low_i))
        else $error("level outside trapezoid bounds");
    AST_STEP_ONE: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i || !wave_en_i)
        (ph_q == tldw_pkg::TLDW_RISE && $past(ph_q) == tldw_pkg::TLDW_RISE)
        |-> (lvl_q - $past(lvl_q) <= 5'h01))
        else $error("ramp skipped a level");
    // A zero delay leaves the start phase on the very next edge, so check the load itself
    AST_DELAY_START: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(wave_en_i) |-> (ph_q == tldw_pkg::TLDW_DELAY && cnt_q == {1'b0, delay_i}))
        else $error("waveform did not start in delay");
endmodule

// ### rtl/tldw_pkg.sv
// Summary of operation
// - With the internal timebase each channel is dimmed by a fixed 20 kHz PWM of its sink current.
// - Every channel keeps its own duty setting, so one channel never disturbs another.
// - A 5-bit code n gives full scale times 0.9 to the power (31 - n).
// - Each channel stores a high and a low code, 0 to 31, that bound its trapezoid when enabled.
// - Code zero turns the channel fully off, outside the exponential scale.
// - The time step register uses only bits 0 to 2 as N; bits 3 to 7 do nothing.
// - The internal time step is 50 us times (N + 1).
// - On waveform enable each channel waits its own delay, time step times an 8-bit delay code.
// - Each ramp step lasts PWM period times 2^N times the rise or fall code; zero counts as a code of one.
// - Each hold lasts PWM period times 2^N times (hold code + 1).
// - Bit 6 of the general control register selects the external sync timebase.
// - With external clocking the PWM period and minimum step are 32 sync periods.
// - General control bits 0-2 enable full level and bits 3-5 enable the waveform per channel.
// - The hardware enable pin low resets all registers and disables the outputs.
package tldw_pkg;
    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h10;
    localparam logic [7:0] ADDR_TIME_STEP = 8'h20;
    localparam logic [7:0] ADDR_CH_BASE = 8'hA0;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h10;
    localparam logic [3:0] SUB_DELAY = 4'h1;
    localparam logic [3:0] SUB_LOW_HOLD = 4'h2;
    localparam logic [3:0] SUB_HIGH_HOLD = 4'h3;
    localparam logic [3:0] SUB_FALL = 4'h4;
    localparam logic [3:0] SUB_RISE = 4'h5;
    localparam logic [3:0] SUB_LOW_LVL = 4'h8;
    localparam logic [3:0] SUB_HIGH_LVL = 4'h9;
    localparam logic [7:0] RST_GEN_CTRL = 8'h00;
    localparam logic [7:0] RST_TIME_STEP = 8'h88;
    localparam logic [7:0] RST_LEVEL = 8'hE0;
    localparam logic [7:0] RST_TIMING = 8'h00;
    localparam int GC_EXT_BIT = 6;
    localparam int GC_WAVE_LSB = 3;
    localparam int TS_N_MSB = 2;
    localparam int LVL_MSB = 4;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_PERIOD_US = 50;
    localparam int PWM_CYCLES = CLK_HZ / 1_000_000 * PWM_PERIOD_US;
    localparam int SYNC_DIV = 32;
    localparam int PWM_RES = 256;
    localparam int PWM_TICK_CYCLES = PWM_CYCLES / PWM_RES;
    localparam logic [4:0] LVL_MAX = 5'h1F;
    typedef enum logic [4:0] {
        TLDW_IDLE = 5'b00001,
        TLDW_DELAY = 5'b00010,
        TLDW_RISE = 5'b00100,
        TLDW_HIGH = 5'b01000,
        TLDW_FALL = 5'b10000
    } tldw_phase_t;
endpackage

// ### rtl/tldw_tick_if.sv
`timescale 1ns/1ps
interface tldw_tick_if;
    logic tick;
    logic [7:0] pwm_cnt;
    logic [2:0] step_n;
    logic base_tick;
    logic step_tick;
    modport src(output tick, output pwm_cnt, output step_n, output base_tick, output step_tick);
    modport snk(input tick, input pwm_cnt, input step_n, input base_tick, input step_tick);
endinterface

// ### rtl/tldw_timebase.sv
`timescale 1ns/1ps
module tldw_timebase (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic ext_sel_i,
    input wire logic sync_i,
    input wire logic [2:0] step_n_i,
    // Tick bus
    tldw_tick_if.src tb
);
    logic [15:0] div_q;
    logic [7:0] pwm_q;
    logic sync_q;
    logic [4:0] sync_cnt_q;
    logic [7:0] base_q;
    logic int_tick;
    logic ext_edge;
    logic sub_tick;
    logic period_end;
    logic [7:0] base_lim;
    logic [2:0] step_q;
    logic step_end;

    // A period is 256 slots; each sync edge advances 8 slots so 32 edges make a period
    assign int_tick = (div_q == 16'(tldw_pkg::PWM_TICK_CYCLES - 1));
    assign ext_edge = sync_i && !sync_q;
    assign sub_tick = ext_sel_i ? ext_edge : int_tick;
    assign period_end = ext_sel_i ? (ext_edge && sync_cnt_q == 5'h1F)
                                  : (int_tick && pwm_q == 8'hFF);
    // Base tick divides PWM periods by 2^N
    assign base_lim = 8'((9'h001 << step_n_i) - 9'h001);
    assign tb.tick = sub_tick;
    assign tb.pwm_cnt = pwm_q;
    assign tb.step_n = step_n_i;
    assign tb.base_tick = period_end && (base_q >= base_lim);
    // Time step is N + 1 PWM periods; it paces the start delay
    assign step_end = period_end && (step_q >= step_n_i);
    assign tb.step_tick = step_end;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_q <= 16'h0000;
            pwm_q <= 8'h00;
            sync_q <= 1'b0;
            sync_cnt_q <= 5'h00;
            base_q <= 8'h00;
            step_q <= 3'h0;
        end else begin
            sync_q <= sync_i;
            div_q <= (int_tick || ext_sel_i) ? 16'h0000 : div_q + 16'h0001;
            if (ext_sel_i && ext_edge) begin
                sync_cnt_q <= sync_cnt_q + 5'h01;
                pwm_q <= {sync_cnt_q + 5'h01, 3'h0};
            end else if (!ext_sel_i && int_tick) begin
                pwm_q <= pwm_q + 8'h01;
            end
            if (period_end) begin
                base_q <= (base_q >= base_lim) ? 8'h00 : base_q + 8'h01;
                step_q <= step_end ? 3'h0 : step_q + 3'h1;
            end
        end
    end
endmodule

// ### rtl/tldw_top.sv
`timescale 1ns/1ps
module tldw_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic hardware_enable_reset_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Sync and outputs
    input wire logic sync_i,
    output logic [2:0] led_pwm_o,
    output logic [14:0] led_level_o
);
    localparam int NCH = 3;
    logic [7:0] gen_q;
    logic [7:0] ts_q;
    logic [7:0] regs_q [NCH][7];
    logic srst_n;
    logic [3:0] sub;
    logic [3:0] ch_off;
    logic [1:0] ch_sel;
    logic ch_hit;
    logic [2:0] ridx;
    logic [2:0] ph [NCH];
    logic [7:0] rd_mux;

    // Channel sub-register index, mapped 0..6
    function automatic logic [2:0] sub_idx(input logic [3:0] s);
        unique case (s)
            tldw_pkg::SUB_DELAY: return 3'h0;
            tldw_pkg::SUB_LOW_HOLD: return 3'h1;
            tldw_pkg::SUB_HIGH_HOLD: return 3'h2;
            tldw_pkg::SUB_FALL: return 3'h3;
            tldw_pkg::SUB_RISE: return 3'h4;
            tldw_pkg::SUB_LOW_LVL: return 3'h5;
            tldw_pkg::SUB_HIGH_LVL: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction

    assign srst_n = rst_n_i && hardware_enable_reset_n_i;
    assign sub = addr_i[3:0];
    // Full offset is compared so addresses above the last channel do not alias
    assign ch_off = addr_i[7:4] - tldw_pkg::ADDR_CH_BASE[7:4];
    assign ch_sel = ch_off[1:0];
    assign ch_hit = (addr_i[7:4] >= tldw_pkg::ADDR_CH_BASE[7:4]) && (ch_off < 4'(NCH));
    assign ridx = sub_idx(sub);
    assign rd_mux = (addr_i == tldw_pkg::ADDR_GEN_CTRL) ? gen_q :
                    (addr_i == tldw_pkg::ADDR_TIME_STEP) ? ts_q :
                    (ch_hit && ridx != 3'h7) ? regs_q[ch_sel][ridx] : 8'h00;

    always_ff @(posedge mclk_i) begin
        if (!srst_n) begin
            gen_q <= tldw_pkg::RST_GEN_CTRL;
            ts_q <= tldw_pkg::RST_TIME_STEP;
            rdata_o <= 8'h00;
            for (int c = 0; c < NCH; c++) begin
                for (int r = 0; r < 5; r++) begin
                    regs_q[c][r] <= tldw_pkg::RST_TIMING;
                end
                regs_q[c][5] <= tldw_pkg::RST_LEVEL;
                regs_q[c][6] <= tldw_pkg::RST_LEVEL;
            end
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
            if (wr_i && addr_i == tldw_pkg::ADDR_GEN_CTRL) begin
                gen_q <= wdata_i;
            end
            if (wr_i && addr_i == tldw_pkg::ADDR_TIME_STEP) begin
                ts_q <= wdata_i;
            end
            if (wr_i && ch_hit && ridx != 3'h7) begin
                regs_q[ch_sel][ridx] <= wdata_i;
            end
        end
    end

    tldw_tick_if tb ();

    tldw_timebase u_tb (
        .mclk_i(mclk_i),
        .rst_n_i(srst_n),
        .ext_sel_i(gen_q[tldw_pkg::GC_EXT_BIT]),
        .sync_i(sync_i),
        .step_n_i(ts_q[tldw_pkg::TS_N_MSB:0]),
        .tb(tb.src)
    );

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        tldw_channel u_ch (
            .mclk_i(mclk_i),
            .rst_n_i(srst_n),
            .level_en_i(gen_q[g]),
            .wave_en_i(gen_q[tldw_pkg::GC_WAVE_LSB + g]),
            .high_i(regs_q[g][6][tldw_pkg::LVL_MSB:0]),
            .low_i(regs_q[g][5][tldw_pkg::LVL_MSB:0]),
            .delay_i(regs_q[g][0]),
            .rise_i(regs_q[g][4]),
            .fall_i(regs_q[g][3]),
            .thigh_i(regs_q[g][2]),
            .tlow_i(regs_q[g][1]),
            .tb(tb.snk),
            .pwm_o(led_pwm_o[g]),
            .level_o(led_level_o[g*5 +: 5]),
            .phase_o(ph[g])
        );
    end

    AST_HARDWARE_ENABLE_RESET_RESET: assert property (@(posedge mclk_i)
        (rst_n_i && !hardware_enable_reset_n_i) |=> (gen_q == 8'h00 && led_pwm_o == 3'h0))
        else $error("enable pin low did not reset");
    AST_WAVE_OFF_PHASE: assert property (@(posedge mclk_i) disable iff (!srst_n)
        !gen_q[tldw_pkg::GC_WAVE_LSB] |=> (ph[0] == 3'h4))
        else $error("disabled channel left its start phase");
    AST_RD_LAT: assert property (@(posedge mclk_i) disable iff (!srst_n)
        (rd_i && addr_i == tldw_pkg::ADDR_GEN_CTRL && !wr_i) |=> (rdata_o == $past(gen_q)))
        else $error("read data late or wrong");
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hw_rst_n = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sync = 1'b0;
    logic [5:0] sync_div = 6'h00;
    logic [7:0] rdata;
    logic [2:0] led_pwm;
    logic [14:0] led_level;
    logic m_start = 1'b0;
    logic [15:0] m_win = 16'h0000;
    logic [2:0][15:0] m_cnt;
    logic m_done;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    localparam int PER = tldw_pkg::PWM_TICK_CYCLES * tldw_pkg::PWM_RES;
    localparam int EPER = 3200;

    always #5 mclk_i = ~mclk_i;
    // Sync source kept at 1 MHz, the highest rate allowed
    always @(posedge mclk_i) begin
        sync_div <= (sync_div == 6'h31) ? 6'h00 : sync_div + 6'h01;
        if (sync_div == 6'h31) begin
            sync <= ~sync;
        end
    end

    tldw_top i_tldw_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .hardware_enable_reset_n_i(hw_rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sync_i(sync),
        .led_pwm_o(led_pwm), .led_level_o(led_level));
    tldw_led_sink i_tldw_led_sink (.mclk_i(mclk_i), .led_pwm_i(led_pwm),
        .start_i(m_start), .win_i(m_win), .on_cnt_o(m_cnt), .done_o(m_done));

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [7:0] ca(input int g, input int s);
        return tldw_pkg::ADDR_CH_BASE + 8'(g) * tldw_pkg::ADDR_CH_STRIDE + 8'(s);
    endfunction
    function automatic int slots(input int c);
        if (c == 0) begin
            return 0;
        end
        return $rtoi(256.0 * (0.9 ** (31 - c)) + 0.5);
    endfunction
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
        n_tests++;
        if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp) begin
            num_errors++;
            $display("[ERR] %0t count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic lvl(input int g, input logic [4:0] exp);
        chk8({3'h0, led_level[5 * g +: 5]}, {3'h0, exp});
    endtask
    task automatic hang();
        num_errors++;
        $display("[ERR] %0t wait limit used up", $time);
        print_verdict();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk8(rdata, exp);
    endtask
    task automatic meas(input int win);
        @(posedge mclk_i);
        m_win <= 16'(win);
        m_start <= 1'b1;
        @(posedge mclk_i);
        m_start <= 1'b0;
        for (int k = 0; k <= win + 4; k++) begin
            @(negedge mclk_i);
            if (m_done === 1'b1) begin
                return;
            end
        end
        hang();
    endtask
    task automatic wait_lvl(input logic [4:0] v);
        for (int k = 0; k < 30000; k++) begin
            @(negedge mclk_i);
            if (led_level[4:0] === v) begin
                return;
            end
        end
        hang();
    endtask
    // Counts whole cycles that channel 0 stays on one code
    task automatic dwell(input logic [4:0] v, output int cnt);
        cnt = 0;
        while (led_level[4:0] === v && cnt < 20000) begin
            @(negedge mclk_i);
            cnt++;
        end
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd_reg(tldw_pkg::ADDR_GEN_CTRL, tldw_pkg::RST_GEN_CTRL);
        rd_reg(tldw_pkg::ADDR_TIME_STEP, tldw_pkg::RST_TIME_STEP);
        for (int g = 0; g < 3; g++) begin
            for (int s = 1; s < 10; s++) begin
                if (s < 6) begin
                    rd_reg(ca(g, s), tldw_pkg::RST_TIMING);
                end
                if (s > 7) begin
                    rd_reg(ca(g, s), tldw_pkg::RST_LEVEL);
                end
            end
        end
        wr_reg(8'h30, 8'h5A);
        rd_reg(8'h30, 8'h00);
        // Addresses past the last channel must not alias onto channel 0
        wr_reg(8'hE1, 8'h77);
        rd_reg(8'hE1, 8'h00);
        rd_reg(ca(0, 1), 8'h00);
        wr_reg(ca(2, 1), 8'hA5);
        rd_reg(ca(2, 1), 8'hA5);
        // Three channels on full level at different codes
        wr_reg(ca(0, 9), 8'h1F);
        wr_reg(ca(1, 9), 8'h1E);
        wr_reg(ca(2, 9), 8'h00);
        wr_reg(tldw_pkg::ADDR_GEN_CTRL, 8'h07);
        repeat (PER) @(posedge mclk_i);
        #1 lvl(0, 5'h1F);
        lvl(1, 5'h1E);
        meas(PER);
        chk_near(m_cnt[0], slots(31) * PER / 256, 20);
        chk_near(m_cnt[1], slots(30) * PER / 256, 40);
        chk_near(m_cnt[2], 0, 0);
        // Hardware enable low clears everything
        @(posedge mclk_i);
        hw_rst_n <= 1'b0;
        @(posedge mclk_i);
        hw_rst_n <= 1'b1;
        #1 lvl(0, 5'h00);
        lvl(1, 5'h00);
        lvl(2, 5'h00);
        rd_reg(tldw_pkg::ADDR_GEN_CTRL, 8'h00);
        rd_reg(ca(2, 1), 8'h00);
        // Trapezoid 1..3 with upper time step bits set but N = 0
        wr_reg(ca(0, 8), 8'h01);
        wr_reg(ca(0, 9), 8'h03);
        wr_reg(tldw_pkg::ADDR_TIME_STEP, 8'hF8);
        wr_reg(tldw_pkg::ADDR_GEN_CTRL, 8'h08);
        wait_lvl(5'h02);
        dwell(5'h02, n);
        chk_near(32'(n), PER, 20);
        lvl(0, 5'h03);
        // Top code stands for the high hold plus the first fall step
        dwell(5'h03, n);
        chk_near(32'(n), 2 * PER, 20);
        lvl(0, 5'h02);
        wait_lvl(5'h01);
        lvl(0, 5'h01);
        // External sync timebase
        wr_reg(ca(0, 9), 8'h10);
        wr_reg(tldw_pkg::ADDR_GEN_CTRL, 8'h41);
        repeat (2 * EPER) @(posedge mclk_i);
        #1 lvl(0, 5'h10);
        meas(EPER);
        // External mode resolves the duty in steps of 8 slots, one per sync edge
        chk_near(m_cnt[0], (slots(16) + 7) / 8 * 8 * EPER / 256, 30);
        print_verdict();
    end
endmodule

// ### test/tldw_led_sink.sv
`timescale 1ns/1ps
module tldw_led_sink (
    // Clock
    input wire logic mclk_i,
    // LED sink gates
    input wire logic [2:0] led_pwm_i,
    // Measurement control
    input wire logic start_i,
    input wire logic [15:0] win_i,
    output logic [2:0][15:0] on_cnt_o,
    output logic done_o
);
    // ********************************************************
    // Conduction time per sink
    // ********************************************************
    logic [15:0] left_q = 16'h0000;
    initial done_o = 1'b0;
    initial on_cnt_o = '0;
    // Each sink conducts only while its own gate is high
    always @(posedge mclk_i) begin
        if (start_i) begin
            left_q <= win_i;
            done_o <= 1'b0;
            on_cnt_o <= '0;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
            done_o <= (left_q == 16'h0001);
            for (int g = 0; g < 3; g++) begin
                on_cnt_o[g] <= on_cnt_o[g] + 16'(led_pwm_i[g]);
            end
        end
    end
endmodule
